// [rtl/acs_start_ctl.sv]
// three-axis start, chain interrupt and resume control
// Contract
// - external start never raises start complete
// - function select 0 means external start
// - enable word 1 validates external start
// - pending interrupt ends chain after current point
// - interrupt request word written with 1
// - resume after interrupted chain gives warning 104
// - accepted interrupt survives stop and resume
// - path point too short postpones the interrupt
// - request ignored when idle, cleared at starts
// - resume continues to original end point
// - resume only from stopped state
// - resume under stop gives error 106
// - host start edge while stopped restarts fresh
// - resume when not stopped warns, keeps running
// - resume works for all chained control kinds
// - stopped state word encodes as 1
// - busy flag high while the axis operates
`default_nettype none
module acs_start_ctl
    import acs_pkg::*;
#(
    parameter int NAX = AXES
)
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [AW-1:0]           reg_addr,
    input  wire logic [DW-1:0]           reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [DW-1:0]           reg_rdata,
    input  wire logic [NAX-1:0]          host_start,
    input  wire logic [NAX-1:0]          stop_cmd,
    input  wire logic [NAX-1:0]          err_reset,
    input  wire logic [NAX-1:0]          ext_start_pin,
    input  wire logic [NAX-1:0]          point_done,
    input  wire logic [NAX-1:0][1:0]     point_pattern,
    input  wire logic [NAX-1:0]          decel_ok,
    input  wire logic [NAX-1:0]          seq_done,
    input  wire logic [NAX-1:0]          motion_stopped,
    output logic      [NAX-1:0]          start_complete_flags,
    output logic      [NAX-1:0]          axis_busy_flags,
    output logic      [NAX-1:0]          launch,
    output logic      [NAX-1:0][DW-1:0]  launch_point,
    output logic      [NAX-1:0]          resume,
    output logic      [NAX-1:0]          chain_end,
    output logic      [NAX-1:0]          chain_halt_pending
);

    // ************************************************************
    // per-axis register copies and status, read by the bus mux
    // ************************************************************
    logic [NAX-1:0][DW-1:0] sel_q;
    logic [NAX-1:0][DW-1:0] ena_q;
    logic [NAX-1:0][DW-1:0] req_q;
    logic [NAX-1:0][DW-1:0] point_q;
    logic [NAX-1:0][DW-1:0] warn_q;
    logic [NAX-1:0][DW-1:0] err_q;
    logic [NAX-1:0][DW-1:0] opst_word;
    logic [DW-1:0]          rdata_d;

    genvar a;
    generate
        for (a = 0; a < NAX; a = a + 1)
        begin : g_axis
            acs_pin_if     pin ();
            acs_state_type state_q;
            acs_state_type state_d;
            logic          intr_q;
            logic          intr_ended_q;
            logic          hstart_q;
            logic          host_rise;
            logic          ext_go;
            logic          host_go;
            logic          start_go;
            logic          rsm_wr;
            logic          rsm_ok;
            logic          intr_wr;
            logic          intr_halt;

            // external start pin crosses into clk here
            assign pin.raw = ext_start_pin[a];

            acs_sync u_sync
            (
                .clk  (clk),
                .rst  (rst),
                .port (pin)
            );

            // ************************************************************
            // event decode
            // ************************************************************
            assign host_rise = host_start[a] && !hstart_q;
            // pin starts only with select and enable programmed first
            assign ext_go    = pin.rise && (sel_q[a] == ACS_SEL_EXT)
                               && (ena_q[a] == ACS_ENA_ON);
            // a stopped axis takes a host edge as a fresh start
            assign host_go   = host_rise && (state_q == ACS_ST_WAIT
                               || state_q == ACS_ST_STOP);
            assign start_go  = host_go
                               || (ext_go && (state_q == ACS_ST_WAIT || state_q == ACS_ST_STOP));
            assign rsm_wr    = reg_wr && (reg_addr == ACS_RSM_ADDR[a])
                               && (reg_wdata == ACS_RSM_ON);
            // resume needs stopped state, stop off, chain not interrupted
            assign rsm_ok    = rsm_wr && (state_q == ACS_ST_STOP)
                               && !stop_cmd[a] && !intr_ended_q;
            // request is only accepted while the axis is busy
            assign intr_wr   = reg_wr && (reg_addr == ACS_INTR_ADDR[a])
                               && axis_busy_flags[a];
            // a path point too short to brake defers the halt
            assign intr_halt = point_done[a] && intr_q && (state_q == ACS_ST_RUN)
                               && ((point_pattern[a] != ACS_PAT_PATH)
                               || decel_ok[a]);

            // ************************************************************
            // axis state machine
            // ************************************************************
            always_comb
            begin
                state_d = state_q;
                case (state_q)
                    ACS_ST_WAIT:
                    begin
                        if (rsm_wr && stop_cmd[a] && !intr_ended_q)
                        begin
                            state_d = ACS_ST_ERR;
                        end
                        else if (start_go)
                        begin
                            state_d = ACS_ST_RUN;
                        end
                    end
                    ACS_ST_RUN:
                    begin
                        // interrupt closes the chain at the point's end
                        if (intr_halt || seq_done[a])
                        begin
                            state_d = ACS_ST_WAIT;
                        end
                        else if (motion_stopped[a])
                        begin
                            state_d = ACS_ST_STOP;
                        end
                    end
                    ACS_ST_STOP:
                    begin
                        if (rsm_wr && stop_cmd[a])
                        begin
                            state_d = ACS_ST_ERR;
                        end
                        else if (rsm_ok || start_go)
                        begin
                            state_d = ACS_ST_RUN;
                        end
                    end
                    default:
                    begin
                        // a resume lost to the error stays lost
                        if (err_reset[a])
                        begin
                            state_d = ACS_ST_WAIT;
                        end
                    end
                endcase
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    state_q  <= ACS_ST_WAIT;
                    hstart_q <= 1'b0;
                end
                else
                begin
                    state_q  <= state_d;
                    hstart_q <= host_start[a];
                end
            end

            // state word seen by software
            always_comb
            begin
                case (state_q)
                    ACS_ST_RUN:  opst_word[a] = ACS_OPST_RUN;
                    ACS_ST_STOP: opst_word[a] = ACS_OPST_STOP;
                    ACS_ST_ERR:  opst_word[a] = ACS_OPST_ERR;
                    default:     opst_word[a] = ACS_OPST_WAIT;
                endcase
            end

            // ************************************************************
            // handshake flags
            // ************************************************************
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    axis_busy_flags[a]      <= 1'b0;
                    start_complete_flags[a] <= 1'b0;
                end
                else
                begin
                    axis_busy_flags[a] <= (state_d == ACS_ST_RUN);
                    // only a host start sets it; pin starts leave it low
                    if (host_go)
                    begin
                        start_complete_flags[a] <= 1'b1;
                    end
                    else if (!host_start[a])
                    begin
                        start_complete_flags[a] <= 1'b0;
                    end
                end
            end

            // ************************************************************
            // commands to the motion engine
            // ************************************************************
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    launch[a]       <= 1'b0;
                    launch_point[a] <= ACS_POINT_RST;
                    resume[a]       <= 1'b0;
                    chain_end[a]    <= 1'b0;
                end
                else
                begin
                    launch[a]    <= start_go && (state_d == ACS_ST_RUN) && !rsm_ok;
                    // fresh start reads the start point register
                    if (start_go && !rsm_ok)
                    begin
                        launch_point[a] <= point_q[a];
                    end
                    // engine resumes from where it stopped to the old end point
                    resume[a]    <= rsm_ok;
                    chain_end[a] <= intr_halt;
                end
            end

            // ************************************************************
            // chain interrupt bookkeeping
            // ************************************************************
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    intr_q                <= 1'b0;
                    intr_ended_q          <= 1'b0;
                    chain_halt_pending[a] <= 1'b0;
                end
                else
                begin
                    // a fresh start forgets everything, a resume does not
                    if (start_go && !rsm_ok)
                    begin
                        intr_q       <= 1'b0;
                        intr_ended_q <= 1'b0;
                    end
                    else if (intr_halt)
                    begin
                        intr_q       <= 1'b0;
                        intr_ended_q <= 1'b1;
                    end
                    else if (intr_wr && reg_wdata == ACS_INTR_ON)
                    begin
                        intr_q <= 1'b1;
                    end
                    // stop does not touch intr_q, so it outlives the stop
                    chain_halt_pending[a] <= intr_q;
                end
            end

            // ************************************************************
            // software words of this axis
            // ************************************************************
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    sel_q[a]   <= ACS_SEL_RST;
                    ena_q[a]   <= ACS_ENA_RST;
                    req_q[a]   <= ACS_WORD_ZERO;
                    point_q[a] <= ACS_POINT_RST;
                end
                else
                begin
                    if (reg_wr && reg_addr == ACS_SEL_ADDR[a])
                    begin
                        sel_q[a] <= reg_wdata;
                    end
                    if (reg_wr && reg_addr == ACS_ENA_ADDR[a])
                    begin
                        ena_q[a] <= reg_wdata;
                    end
                    if (reg_wr && reg_addr == ACS_POINT_ADDR[a])
                    begin
                        point_q[a] <= reg_wdata;
                    end
                    // word cleared at start and resume, start wins a collision
                    if (start_go || rsm_ok)
                    begin
                        req_q[a] <= ACS_WORD_ZERO;
                    end
                    else if (intr_wr)
                    begin
                        req_q[a] <= reg_wdata;
                    end
                end
            end

            // ************************************************************
            // warning and error codes, set beats the reset input
            // ************************************************************
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    warn_q[a] <= ACS_WORD_ZERO;
                    err_q[a]  <= ACS_WORD_ZERO;
                end
                else
                begin
                    if (rsm_wr && intr_ended_q)
                    begin
                        warn_q[a] <= ACS_WARN_NORSM;
                    end
                    else if (rsm_wr && state_q != ACS_ST_STOP && !(stop_cmd[a] && state_q == ACS_ST_WAIT))
                    begin
                        // running move carries on untouched
                        warn_q[a] <= ACS_WARN_MULTI;
                    end
                    else if (host_rise && state_q == ACS_ST_RUN)
                    begin
                        warn_q[a] <= ACS_WARN_BUSY;
                    end
                    else if (err_reset[a])
                    begin
                        warn_q[a] <= ACS_WORD_ZERO;
                    end

                    if (state_d == ACS_ST_ERR && state_q != ACS_ST_ERR)
                    begin
                        err_q[a] <= ACS_ERR_STOPON;
                    end
                    else if (err_reset[a])
                    begin
                        err_q[a] <= ACS_WORD_ZERO;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // register read port
    // ************************************************************
    // unmapped and write-only words read as zero
    always_comb
    begin
        rdata_d = ACS_WORD_ZERO;
        for (int i = 0; i < NAX; i++)
        begin
            if (reg_addr == ACS_SEL_ADDR[i])
            begin
                rdata_d = sel_q[i];
            end
            else if (reg_addr == ACS_ENA_ADDR[i])
            begin
                rdata_d = ena_q[i];
            end
            else if (reg_addr == ACS_INTR_ADDR[i])
            begin
                rdata_d = req_q[i];
            end
            else if (reg_addr == ACS_POINT_ADDR[i])
            begin
                rdata_d = point_q[i];
            end
            else if (reg_addr == ACS_OPST_ADDR[i])
            begin
                rdata_d = opst_word[i];
            end
            else if (reg_addr == ACS_WARN_ADDR[i])
            begin
                rdata_d = warn_q[i];
            end
            else if (reg_addr == ACS_ERR_ADDR[i])
            begin
                rdata_d = err_q[i];
            end
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata <= ACS_WORD_ZERO;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_d : ACS_WORD_ZERO;
        end
    end

endmodule
`default_nettype wire

// [rtl/acs_sync.sv]
// three-flop synchroniser with agreement filter and rising edge pulse
`default_nettype none
module acs_sync
    import acs_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    acs_pin_if.sync_side      port
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic rise_q;

    // chain; only s2 reads s1
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= port.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // level moves only when the two settled flops agree
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end
        else
        begin
            if (s2_q == s3_q)
            begin
                level_q <= s3_q;
            end
            rise_q <= (s2_q == s3_q) && s3_q && !level_q;
        end
    end

    assign port.level = level_q;
    assign port.rise  = rise_q;
endmodule
`default_nettype wire

// [shared/acs_pin_if.sv]
// carrier between a pin synchroniser and its user
`default_nettype none
interface acs_pin_if;
    logic raw;
    logic level;
    logic rise;

    modport sync_side (input raw, output level, output rise);
    modport user_side (output raw, input level, input rise);
endinterface
`default_nettype wire

// [shared/acs_pkg.sv]
// constants, codes and register map of the axis start/interrupt/restart control
`default_nettype none
package acs_pkg;

    localparam int AXES = 3;
    localparam int AW   = 11;
    localparam int DW   = 16;

    // ************************************************************
    // register word addresses, packed as {axis3, axis2, axis1}
    // ************************************************************
    localparam logic [2:0][10:0] ACS_SEL_ADDR   = {11'h16A, 11'h0D4, 11'h03E};
    localparam logic [2:0][10:0] ACS_ENA_ADDR   = {11'h4F7, 11'h4C5, 11'h493};
    localparam logic [2:0][10:0] ACS_INTR_ADDR  = {11'h501, 11'h4CF, 11'h49D};
    localparam logic [2:0][10:0] ACS_RSM_ADDR   = {11'h4E4, 11'h4B2, 11'h480};
    localparam logic [2:0][10:0] ACS_POINT_ADDR = {11'h4E2, 11'h4B0, 11'h47E};
    localparam logic [2:0][10:0] ACS_OPST_ADDR  = {11'h3E8, 11'h384, 11'h320};
    localparam logic [2:0][10:0] ACS_WARN_ADDR  = {11'h3E9, 11'h385, 11'h321};
    localparam logic [2:0][10:0] ACS_ERR_ADDR   = {11'h3EA, 11'h386, 11'h322};

    // ************************************************************
    // field values and reset values
    // ************************************************************
    localparam logic [15:0] ACS_SEL_EXT     = 16'h0000;
    localparam logic [15:0] ACS_SEL_RST     = 16'h0000;
    localparam logic [15:0] ACS_ENA_ON      = 16'h0001;
    localparam logic [15:0] ACS_ENA_RST     = 16'h0000;
    localparam logic [15:0] ACS_INTR_ON     = 16'h0001;
    localparam logic [15:0] ACS_RSM_ON      = 16'h0001;
    localparam logic [15:0] ACS_POINT_RST   = 16'h0001;
    localparam logic [15:0] ACS_WORD_ZERO   = 16'h0000;

    // operation state word encodings
    localparam logic [15:0] ACS_OPST_WAIT   = 16'h0000;
    localparam logic [15:0] ACS_OPST_STOP   = 16'h0001;
    localparam logic [15:0] ACS_OPST_RUN    = 16'h0008;
    localparam logic [15:0] ACS_OPST_ERR    = 16'hFFFF;

    // warning and error codes
    localparam logic [15:0] ACS_WARN_BUSY   = 16'h0064;
    localparam logic [15:0] ACS_WARN_MULTI  = 16'h0065;
    localparam logic [15:0] ACS_WARN_NORSM  = 16'h0068;
    localparam logic [15:0] ACS_ERR_STOPON  = 16'h006A;

    // data point patterns
    localparam logic [1:0]  ACS_PAT_END     = 2'h0;
    localparam logic [1:0]  ACS_PAT_CONT    = 2'h1;
    localparam logic [1:0]  ACS_PAT_PATH    = 2'h3;

    // axis control states, gray along wait -> run -> stopped -> error
    typedef enum logic [1:0] {
        ACS_ST_WAIT = 2'h0,
        ACS_ST_RUN  = 2'h1,
        ACS_ST_STOP = 2'h3,
        ACS_ST_ERR  = 2'h2
    } acs_state_type;

endpackage
`default_nettype wire

// [test/acs_chk.sv]
// assertions on axis 1 of the start control ports
`default_nettype none
module acs_chk
    import acs_pkg::*;
#(
    parameter int NAX = AXES
)
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [NAX-1:0]      host_start,
    input wire logic [NAX-1:0]      stop_cmd,
    input wire logic [NAX-1:0]      point_done,
    input wire logic [NAX-1:0][1:0] point_pattern,
    input wire logic [NAX-1:0]      decel_ok,
    input wire logic [NAX-1:0]      start_complete_flags,
    input wire logic [NAX-1:0]      axis_busy_flags,
    input wire logic [NAX-1:0]      launch,
    input wire logic [NAX-1:0]      resume,
    input wire logic [NAX-1:0]      chain_end,
    input wire logic [NAX-1:0]      chain_halt_pending
);
    // ****
    // one domain, so shared clocking and reset
    // ****
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    property p_pin_cpl;
        launch[0] && !$past(host_start[0]) && !$past(host_start[0], 2) |-> !start_complete_flags[0];
    endproperty
    a_pin_cpl: assert property (p_pin_cpl) else $error("pin start raised complete");
    property p_busy; launch[0] || resume[0] |-> axis_busy_flags[0]; endproperty
    a_busy: assert property (p_busy) else $error("busy low at start");
    property p_end; chain_end[0] |-> $past(point_done[0]) ##1 !axis_busy_flags[0]; endproperty
    a_end: assert property (p_end) else $error("chain end out of place");
    property p_late; point_done[0] && point_pattern[0] == ACS_PAT_PATH && !decel_ok[0] |=> !chain_end[0]; endproperty
    a_late: assert property (p_late) else $error("short point not postponed");
    property p_req; $rose(chain_halt_pending[0]) |-> $past(axis_busy_flags[0], 2); endproperty
    a_req: assert property (p_req) else $error("request taken while idle");
    property p_clr; launch[0] |=> !chain_halt_pending[0]; endproperty
    a_clr: assert property (p_clr) else $error("request kept over start");
    property p_stp; resume[0] |-> !$past(stop_cmd[0]); endproperty
    a_stp: assert property (p_stp) else $error("resume under stop");
    property p_nors; chain_end[0] ##1 (!launch[0]) [*4] |-> !resume[0]; endproperty
    a_nors: assert property (p_nors) else $error("resume after chain end");
endmodule
bind acs_start_ctl acs_chk #(.NAX(NAX)) chk (.clk, .rst, .host_start, .stop_cmd, .point_done, .point_pattern,
    .decel_ok, .start_complete_flags, .axis_busy_flags, .launch, .resume, .chain_end, .chain_halt_pending);
`default_nettype wire

// [test/acs_eng_mdl.sv]
// stand-in for the motion engine behind the start control
`default_nettype none
module acs_eng_mdl
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] run_go,
    input  wire logic [2:0] run_end,
    input  wire logic [2:0] stop_cmd,
    output logic      [2:0] point_done,
    output logic      [2:0] motion_stopped
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] run_q;
    logic [1:0] tick_q;
    // a point ends every fourth cycle; none while braking, so a stop never races a point end
    always_ff @(posedge clk)
    begin
        run_q          <= rst ? 3'h0 : (run_q | run_go) & ~run_end & ~motion_stopped;
        tick_q         <= rst ? 2'h0 : tick_q + 2'h1;
        point_done     <= rst ? 3'h0 : run_q & {3{tick_q == 2'h3}} & ~stop_cmd;
        motion_stopped <= rst ? 3'h0 : run_q & stop_cmd & ~motion_stopped;
    end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the axis start control
`default_nettype none
module tb_top
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk, rst, reg_wr, reg_rd;
    logic [AW-1:0]   reg_addr;
    logic [DW-1:0]   reg_wdata, reg_rdata;
    logic [2:0]      host_start, stop_cmd, err_reset, ext_start_pin, point_done, decel_ok, motion_stopped, seq_done;
    logic [2:0][15:0] launch_point;
    logic [2:0]      start_complete_flags, axis_busy_flags, launch, resume, chain_end, chain_halt_pending;
    logic [2:0][1:0] point_pattern;
    logic [4:0]      ev;
    int              failures = 0;
    int              checked = 0;
    acs_start_ctl uut (.*);
    acs_eng_mdl eng (.*, .run_go(launch | resume), .run_end(chain_end));
    // axis 1 events the waits look for
    assign ev = {motion_stopped[0], point_done[0], resume[0], chain_end[0], launch[0]};
    always #10 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one strobe cycle; a read compares the word of the next cycle
    task automatic bus(input logic w, input logic [10:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'h0;
        if (!w)
            #1 chk("word", d, reg_rdata);
    endtask
    // bounded wait for one event; a miss ends the run
    task automatic wt(input int k);
        int n;
        for (n = 0; n < 99; n++)
        begin
            #1;
            if (ev[k] === 1'b1)
                break;
            @(posedge clk);
        end
        if (n == 99)
        begin
            failures++;
            end_sim;
        end
    endtask
    task automatic s_pin;
        bus(0, ACS_OPST_ADDR[0], ACS_OPST_WAIT);
        bus(0, 11'h7FF, ACS_WORD_ZERO);
        bus(1, ACS_SEL_ADDR[0], ACS_SEL_EXT);
        bus(1, ACS_ENA_ADDR[0], ACS_ENA_ON);
        @(posedge clk);
        ext_start_pin <= 3'h1;
        wt(0);
        chk("complete", 16'h0, 16'(start_complete_flags[0]));
        bus(0, ACS_OPST_ADDR[0], ACS_OPST_RUN);
        @(posedge clk);
        ext_start_pin <= 3'h0;
    endtask
    // short path point postpones, continuous point ends the chain
    task automatic s_intr;
        bus(1, ACS_INTR_ADDR[0], ACS_INTR_ON);
        wt(3);
        @(posedge clk);
        point_pattern <= {3{ACS_PAT_CONT}};
        #1 chk("pend end", 16'h1, {14'h0, chain_end[0], chain_halt_pending[0]});
        wt(1);
        @(posedge clk);
        #1 chk("busy", 16'h0, 16'(axis_busy_flags[0]));
        bus(1, ACS_RSM_ADDR[0], ACS_RSM_ON);
        bus(0, ACS_WARN_ADDR[0], ACS_WARN_NORSM);
    endtask
    // host start, resume while running, after stop, and under stop
    task automatic s_resume;
        bus(1, ACS_POINT_ADDR[0], 16'h0007);
        err_reset <= 3'h1;
        @(posedge clk);
        err_reset <= 3'h0;
        host_start <= 3'h1;
        wt(0);
        chk("complete", 16'h1, 16'(start_complete_flags[0]));
        chk("point", 16'h0007, launch_point[0]);
        bus(0, ACS_INTR_ADDR[0], ACS_WORD_ZERO);
        bus(1, ACS_RSM_ADDR[0], ACS_RSM_ON);
        bus(0, ACS_WARN_ADDR[0], ACS_WARN_MULTI);
        @(posedge clk);
        stop_cmd <= 3'h1;
        wt(4);
        bus(0, ACS_OPST_ADDR[0], ACS_OPST_STOP);
        @(posedge clk);
        stop_cmd <= 3'h0;
        bus(1, ACS_RSM_ADDR[0], ACS_RSM_ON);
        wt(2);
        @(posedge clk);
        stop_cmd <= 3'h1;
        wt(4);
        bus(1, ACS_RSM_ADDR[0], ACS_RSM_ON);
        bus(0, ACS_ERR_ADDR[0], ACS_ERR_STOPON);
        bus(0, ACS_OPST_ADDR[0], ACS_OPST_ERR);
    endtask
    // error reset still gives no resume; a finished sequence drops busy
    task automatic s_done;
        @(posedge clk);
        err_reset <= 3'h1;
        stop_cmd <= 3'h0;
        host_start <= 3'h0;
        @(posedge clk);
        err_reset <= 3'h0;
        bus(1, ACS_RSM_ADDR[0], ACS_RSM_ON);
        bus(0, ACS_WARN_ADDR[0], ACS_WARN_MULTI);
        @(posedge clk);
        host_start <= 3'h1;
        wt(0);
        chk("busy", 16'h1, 16'(axis_busy_flags[0]));
        @(posedge clk);
        seq_done <= 3'h1;
        @(posedge clk);
        seq_done <= 3'h0;
        #1 chk("busy", 16'h0, 16'(axis_busy_flags[0]));
    endtask
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata, host_start, stop_cmd, err_reset, ext_start_pin, decel_ok, seq_done} = '0;
        point_pattern = {3{ACS_PAT_PATH}};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        s_pin;
        s_intr;
        s_resume;
        s_done;
        end_sim;
    end
endmodule
`default_nettype wire
